// ==== verilog/sltc_top.sv ====
// Purpose: Link layer control of the serial lane transmitter
// Assumes: Serial control pins and sync pin are asynchronous to mclk_i
// Notes:   Octets with a control flag go to an external 8b/10b encoder
`timescale 1ns/10ps
module sltc_top
    import sltc_pkg::*;
#(
    parameter int SAMPLE_W   = 14,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                mclk_i,
    input  wire logic                rst_n_i,
    input  wire logic                spi_sen_n_i,
    input  wire logic                spi_sclk_i,
    input  wire logic                spi_sdi_i,
    output logic                     spi_sdo_o,
    input  wire logic                sync_request_pin_n_i,
    input  wire logic [4:0]          frames_per_mf_i,
    input  wire logic                sample_valid_i,
    output logic                     sample_ready_o,
    input  wire logic [SAMPLE_W-1:0] sample_i,
    output logic [7:0]               tx_data_o,
    output logic                     tx_ctrl_o,
    output logic [1:0]               link_state_o
);
    initial begin
        if (SAMPLE_W != 14)
            $error("sltc_top: SAMPLE_W must be 14");
    end

    // ******************************************************************
    // Pin synchronisers
    // ******************************************************************
    logic [1:0] sen_s_r;
    logic [2:0] sclk_s_r;
    logic [1:0] sdi_s_r;
    logic [1:0] syncp_s_r;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sen_s_r   <= 2'h3;
            sclk_s_r  <= 3'h0;
            sdi_s_r   <= 2'h0;
            syncp_s_r <= 2'h0;
        end else begin
            sen_s_r   <= {sen_s_r[0], spi_sen_n_i};
            sclk_s_r  <= {sclk_s_r[1:0], spi_sclk_i};
            sdi_s_r   <= {sdi_s_r[0], spi_sdi_i};
            syncp_s_r <= {syncp_s_r[0], sync_request_pin_n_i};
        end
    end

    // ******************************************************************
    // Serial control port, 16-bit frames: rd, 7-bit address, data
    // ******************************************************************
    logic       sclk_rise;
    logic [3:0] bit_cnt_r;
    logic [14:0] shin_r;
    logic [7:0] sdo_sh_r;
    logic [7:0] align_ctrl_r;
    logic [7:0] sync_fmt_r;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;
    logic       wr_go;

    assign sclk_rise = sclk_s_r[1] && !sclk_s_r[2];
    assign rd_addr   = {shin_r[5:0], sdi_s_r[1]};
    assign wr_go     = !sen_s_r[1] && sclk_rise && bit_cnt_r == SPI_LAST
                       && !shin_r[14];

    always_comb begin
        case (rd_addr)
            ALIGN_CTRL_ADDR: rd_data = align_ctrl_r;
            SYNC_FMT_ADDR:   rd_data = sync_fmt_r;
            default:         rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_cnt_r <= 4'h0;
            shin_r    <= 15'h0000;
        end else if (sen_s_r[1]) begin
            bit_cnt_r <= 4'h0;
        end else if (sclk_rise) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            shin_r    <= {shin_r[13:0], sdi_s_r[1]};
        end
    end

    // Read data appears after the eighth rising clock of a read frame
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sdo_sh_r <= 8'h00;
        end else if (sen_s_r[1]) begin
            sdo_sh_r <= 8'h00;
        end else if (sclk_rise && bit_cnt_r == SPI_RD_BIT && shin_r[6]) begin
            sdo_sh_r <= rd_data;
        end else if (sclk_rise) begin
            sdo_sh_r <= {sdo_sh_r[6:0], 1'b0};
        end
    end
    assign spi_sdo_o = sdo_sh_r[7];

    // Must-write-zero bits are dropped, so they read back as zero
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            align_ctrl_r <= ALIGN_CTRL_RST;
            sync_fmt_r   <= SYNC_FMT_RST;
        end else if (wr_go && shin_r[13:7] == ALIGN_CTRL_ADDR) begin
            align_ctrl_r <= {shin_r[6:0], sdi_s_r[1]} & ALIGN_CTRL_MASK;
        end else if (wr_go && shin_r[13:7] == SYNC_FMT_ADDR) begin
            sync_fmt_r <= {shin_r[6:0], sdi_s_r[1]} & SYNC_FMT_MASK;
        end
    end

    // ******************************************************************
    // Frame and multiframe counters
    // ******************************************************************
    logic [5:0] k_len;
    logic [4:0] f_len;
    logic [3:0] oc_r;
    logic [4:0] fc_r;
    logic       oc_last;
    logic       mf_last;
    logic       packed_on;
    logic       sync_req;
    sltc_state_t st_r;
    sltc_state_t st_nxt;

    assign k_len = align_ctrl_r[K_OVERRIDE_BIT]
                   ? {1'b0, frames_per_mf_i} + 6'h01
                   : K_DEFAULT;

    always_comb begin
        case (sync_fmt_r[LAYOUT_LSB +: 2])
            2'h0:    f_len = FRAME_OCT_0;
            2'h1:    f_len = FRAME_OCT_1;
            2'h2:    f_len = FRAME_OCT_2;
            default: f_len = FRAME_OCT_3;
        endcase
    end

    assign oc_last   = {1'b0, oc_r} >= f_len - 5'h01;
    assign mf_last   = oc_last && {1'b0, fc_r} >= k_len - 6'h01;
    assign packed_on = sync_fmt_r[PACKED_LSB +: 2] == PACKED_ON;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oc_r <= 4'h0;
            fc_r <= 5'h00;
        end else begin
            oc_r <= oc_last ? 4'h0 : oc_r + 4'h1;
            if (mf_last)
                fc_r <= 5'h00;
            else if (oc_last)
                fc_r <= fc_r + 5'h01;
        end
    end

    // ******************************************************************
    // Link state: sync, alignment sequence, data
    // ******************************************************************
    logic [1:0] ila_mf_r;

    assign sync_req = sync_fmt_r[SOFT_SYNC_SEL] ? sync_fmt_r[SOFT_SYNC_REQ]
                      : !syncp_s_r[1];

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_SYNC: if (!sync_req && mf_last) begin
                st_nxt = align_ctrl_r[ILA_SKIP_BIT] ? ST_DATA
                                                    : ST_ILA;
            end
            ST_ILA:  if (mf_last && ila_mf_r == ILA_MF_LAST) begin
                st_nxt = ST_DATA;
            end
            ST_DATA: st_nxt = ST_DATA;
            default: st_nxt = ST_SYNC;
        endcase
        if (sync_req)
            st_nxt = ST_SYNC;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r     <= ST_SYNC;
            ila_mf_r <= 2'h0;
        end else begin
            st_r <= st_nxt;
            if (st_r != ST_ILA)
                ila_mf_r <= 2'h0;
            else if (mf_last)
                ila_mf_r <= ila_mf_r + 2'h1;
        end
    end
    assign link_state_o = st_r;

    // ******************************************************************
    // Sample path and octet assembly
    // ******************************************************************
    sltc_stream_if #(.WIDTH(SAMPLE_W)) smp_s ();

    sltc_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk_i     (mclk_i),
        .rst_n_i    (rst_n_i),
        .in_valid_i (sample_valid_i),
        .in_ready_o (sample_ready_o),
        .in_data_i  (sample_i),
        .out_s      (smp_s.src)
    );

    logic [1:0]          ph_r;
    logic [SAMPLE_W-1:0] hold_r;
    logic [SAMPLE_W-1:0] pat_r;
    logic [SAMPLE_W-1:0] cur;
    logic                need;
    logic                pop;
    logic [7:0]          oct;

    // Packed mode: two 12-bit samples per three octets
    assign need = st_r == ST_DATA
                  && (ph_r == 2'h0 || (packed_on && ph_r == 2'h1));
    assign pop  = need && !align_ctrl_r[PATTERN_EN_BIT];
    assign smp_s.ready = pop;
    assign cur  = align_ctrl_r[PATTERN_EN_BIT] ? pat_r
                  : (smp_s.valid ? smp_s.data : '0);

    always_comb begin
        case (ph_r)
            2'h0:    oct = cur[13:6];
            2'h1:    oct = packed_on ? {hold_r[5:2], cur[13:10]}
                                     : {hold_r[5:0], 2'h0};
            default: oct = hold_r[9:2];
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ph_r   <= 2'h0;
            hold_r <= '0;
            pat_r  <= '0;
        end else if (st_r != ST_DATA) begin
            ph_r  <= 2'h0;
            pat_r <= '0;
        end else begin
            if (need)
                hold_r <= cur;
            if (need && align_ctrl_r[PATTERN_EN_BIT])
                pat_r <= pat_r + 1'b1;
            // Packing may be turned off mid-sample; never step past the end
            if (ph_r >= (packed_on ? 2'h2 : 2'h1))
                ph_r <= 2'h0;
            else
                ph_r <= ph_r + 2'h1;
        end
    end

    // ******************************************************************
    // Lane output
    // ******************************************************************
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_data_o <= K28_5;
            tx_ctrl_o <= 1'b1;
        end else begin
            tx_ctrl_o <= 1'b1;
            case (st_r)
                ST_SYNC: tx_data_o <= K28_5;
                ST_ILA: begin
                    if (oc_r == 4'h0 && fc_r == 5'h00)
                        tx_data_o <= K28_0;
                    else if (mf_last)
                        tx_data_o <= K28_3;
                    else if (ila_mf_r == 2'h1 && oc_r == 4'h1 && fc_r == 5'h00)
                        tx_data_o <= K28_4;
                    else begin
                        tx_data_o <= {3'h0, fc_r};
                        tx_ctrl_o <= 1'b0;
                    end
                end
                default: begin
                    if (mf_last && align_ctrl_r[LANE_MARK_BIT])
                        tx_data_o <= K28_3;
                    else if (oc_last && align_ctrl_r[FRAME_MARK_BIT])
                        tx_data_o <= K28_7;
                    else begin
                        tx_data_o <= oct;
                        tx_ctrl_o <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ******************************************************************
    // Assertions
    // ******************************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence mf_end_s;
        mf_last;
    endsequence

    mf_wrap_a: assert property (mf_end_s
        |=> fc_r == 5'h00 && oc_r == 4'h0)
        else $error("multiframe counter did not wrap");
    k_len_a: assert property (!align_ctrl_r[K_OVERRIDE_BIT] && oc_last
        && fc_r == 5'h04 |-> mf_last)
        else $error("default multiframe is not five frames");
    frame_len_a: assert property (oc_r == f_len[3:0] - 4'h1
        |-> oc_last)
        else $error("frame length does not follow layout");
    sync_out_a: assert property (st_r == ST_SYNC |=> tx_data_o == K28_5
        && tx_ctrl_o)
        else $error("sync state did not send K28.5");
    soft_sync_a: assert property (sync_fmt_r[SOFT_SYNC_SEL]
        && sync_fmt_r[SOFT_SYNC_REQ] |=> st_r == ST_SYNC)
        else $error("soft sync request ignored");
    soft_sel_a: assert property (sync_fmt_r[SOFT_SYNC_SEL]
        && !sync_fmt_r[SOFT_SYNC_REQ] && st_r != ST_SYNC
        |=> st_r != ST_SYNC)
        else $error("sync pin not ignored");
    ila_skip_a: assert property (align_ctrl_r[ILA_SKIP_BIT]
        && st_r == ST_SYNC ##1 st_r != ST_SYNC |-> st_r == ST_DATA)
        else $error("alignment sequence sent while skipped");
    ila_start_a: assert property (st_r == ST_SYNC ##1 st_r == ST_ILA
        |=> tx_data_o == K28_0 && tx_ctrl_o)
        else $error("alignment sequence did not start with K28.0");
    lane_mark_a: assert property (st_r == ST_DATA && mf_last
        && align_ctrl_r[LANE_MARK_BIT] |=> tx_data_o == K28_3)
        else $error("lane marker missing");
    frame_mark_a: assert property (st_r == ST_DATA && oc_last && !mf_last
        && align_ctrl_r[FRAME_MARK_BIT] |=> tx_data_o == K28_7)
        else $error("frame marker missing");
    pattern_pop_a: assert property (align_ctrl_r[PATTERN_EN_BIT]
        |-> !pop)
        else $error("samples consumed during test pattern");
    packed_phase_a: assert property (!packed_on && st_r == ST_DATA
        |=> ph_r != 2'h2)
        else $error("packed phase in 14-bit mode");

endmodule // sltc_top

// ==== verilog/sltc_pkg.sv ====
// Purpose: Shared constants of the serial link transmit control block
// Assumes: One clock, octets leave towards an external 8b/10b encoder
// Notes:   Register map is reached over the serial control port
//
// What this block does
// - Override bit picks programmed length, else five.
// - Programmed frames per multiframe equals field plus one.
// - Pattern enable sends test pattern, not samples.
// - Lane marker bit inserts K28.3 at multiframe ends.
// - Frame marker bit inserts K28.7 at frame ends not given K28.3 by the lane marker.
// - Skip bit omits alignment sequence after sync release.
// - Soft sync request replaces all data with K28.5 while soft sync select is set.
// - Soft sync select ignores the sync request pins.
// - Packed field 00 gives 14-bit, 11 gives 12-bit packing.
// - Frame layout field selects the frame assembly.
package sltc_pkg;

    // ******************************************************************
    // Register map
    // ******************************************************************
    localparam logic [6:0] ALIGN_CTRL_ADDR = 7'h01;
    localparam logic [6:0] SYNC_FMT_ADDR   = 7'h02;
    localparam logic [7:0] ALIGN_CTRL_RST  = 8'h00;
    localparam logic [7:0] SYNC_FMT_RST    = 8'h00;
    localparam logic [7:0] ALIGN_CTRL_MASK = 8'h97;
    localparam logic [7:0] SYNC_FMT_MASK   = 8'hCF;

    localparam int K_OVERRIDE_BIT   = 7;
    localparam int PATTERN_EN_BIT   = 4;
    localparam int LANE_MARK_BIT    = 2;
    localparam int FRAME_MARK_BIT   = 1;
    localparam int ILA_SKIP_BIT     = 0;
    localparam int SOFT_SYNC_REQ    = 7;
    localparam int SOFT_SYNC_SEL    = 6;
    localparam int PACKED_LSB       = 2;
    localparam int LAYOUT_LSB       = 0;
    localparam logic [1:0] PACKED_ON = 2'h3;

    // ******************************************************************
    // Link constants
    // ******************************************************************
    localparam logic [5:0] K_DEFAULT   = 6'h05;
    localparam logic [1:0] ILA_MF_LAST = 2'h3;
    localparam logic [7:0] K28_0       = 8'h1C;
    localparam logic [7:0] K28_3       = 8'h7C;
    localparam logic [7:0] K28_4       = 8'h9C;
    localparam logic [7:0] K28_5       = 8'hBC;
    localparam logic [7:0] K28_7       = 8'hFC;
    localparam logic [3:0] SPI_RD_BIT  = 4'h7;
    localparam logic [3:0] SPI_LAST    = 4'hF;

    // Octets per frame for each frame layout code
    localparam logic [4:0] FRAME_OCT_0 = 5'h02;
    localparam logic [4:0] FRAME_OCT_1 = 5'h04;
    localparam logic [4:0] FRAME_OCT_2 = 5'h08;
    localparam logic [4:0] FRAME_OCT_3 = 5'h10;

    typedef enum logic [1:0] {ST_SYNC, ST_ILA, ST_DATA} sltc_state_t;

endpackage

// ==== verilog/sltc_stream_if.sv ====
// Purpose: Sample stream between the FIFO and the link framer
// Assumes: Valid and ready handshake on mclk_i
// Notes:   Transfer when valid and ready are both high
`timescale 1ns/10ps
interface sltc_stream_if #(parameter int WIDTH = 14);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ==== verilog/sltc_fifo.sv ====
// Purpose: Sample FIFO in front of the link framer
// Assumes: DEPTH is a power of two, at least two
// Notes:   Full and empty come from pointers with a wrap bit
`timescale 1ns/10ps
module sltc_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    sltc_stream_if.src            out_s
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("sltc_fifo: DEPTH must be a power of two");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wp_r;
    logic [AW:0]      rp_r;
    logic             full;
    logic             empty;

    assign empty = (wp_r == rp_r);
    assign full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign in_ready_o  = !full;
    assign out_s.valid = !empty;
    assign out_s.data  = mem_r[rp_r[AW-1:0]];

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_r <= '0;
        end else if (in_valid_i && !full) begin
            wp_r <= wp_r + 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (in_valid_i && !full) begin
            mem_r[wp_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rp_r <= '0;
        end else if (out_s.ready && !empty) begin
            rp_r <= rp_r + 1'b1;
        end
    end

endmodule // sltc_fifo

// ==== dv/sltc_rx_model.sv ====
// Purpose: Behavioural lane receiver that drives the sync request pin
// Assumes: One octet per mclk with a control flag beside it
// Notes:   hold_i keeps sync requested while the bench commands it
`timescale 1ns/10ps
module sltc_rx_model
    import sltc_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] rx_data_i,
    input  wire logic       rx_ctrl_i,
    input  wire logic       hold_i,
    output logic            sync_n_o
);
    logic [2:0] kcnt_r;
    logic       lock_r;

    // Lock after four K28.5 in a row, then release sync
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            kcnt_r <= 3'h0;
            lock_r <= 1'b0;
        end else if (hold_i) begin
            kcnt_r <= 3'h0;
            lock_r <= 1'b0;
        end else if (rx_ctrl_i && rx_data_i == K28_5) begin
            kcnt_r <= (kcnt_r == 3'h4) ? kcnt_r : kcnt_r + 3'h1;
            lock_r <= lock_r | (kcnt_r == 3'h3);
        end else begin
            kcnt_r <= 3'h0;
        end
    end

    assign sync_n_o = lock_r;
endmodule // sltc_rx_model

// ==== dv/tb_top.sv ====
// Purpose: Self-checking bench of the serial link transmit control
// Assumes: Bench drives inputs 1 ns after each rising mclk edge
// Notes:   Receiver model drives the sync request pin
`timescale 1ns/10ps
module tb_top;
    import sltc_pkg::*;
    logic        mclk, rst_n, sen_n, sclk, sdi, sdo, pin_n, hold;
    logic [4:0]  fpm;
    logic        sv, sr, txc;
    logic [13:0] smp;
    logic [7:0]  txd;
    logic [1:0]  st;
    int          fail_count, n_compared, cycles;

    sltc_top i_dut (
        .mclk_i              (mclk),
        .rst_n_i             (rst_n),
        .spi_sen_n_i         (sen_n),
        .spi_sclk_i          (sclk),
        .spi_sdi_i           (sdi),
        .spi_sdo_o           (sdo),
        .sync_request_pin_n_i(pin_n),
        .frames_per_mf_i     (fpm),
        .sample_valid_i      (sv),
        .sample_ready_o      (sr),
        .sample_i            (smp),
        .tx_data_o           (txd),
        .tx_ctrl_o           (txc),
        .link_state_o        (st)
    );
    sltc_rx_model i_rx (
        .mclk_i   (mclk),
        .rst_n_i  (rst_n),
        .rx_data_i(txd),
        .rx_ctrl_i(txc),
        .hold_i   (hold),
        .sync_n_o (pin_n)
    );

    always #2.5 mclk = ~mclk;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic spi(input logic rd, input logic [6:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        logic [15:0] w;
        w = {rd, a, d};
        q = 8'h00;
        sen_n = 1'b0;
        tick(4);
        for (int i = 15; i >= 0; i--) begin
            sdi = w[i];
            tick(4);
            if (i < 8) q[i] = sdo;
            sclk = 1'b1;
            tick(4);
            sclk = 1'b0;
        end
        tick(6);
        sen_n = 1'b1;
        tick(6);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        spi(1'b0, a, d, q);
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] q;
        spi(1'b1, a, 8'h00, q);
        chk(q === e, "register read");
    endtask
    task automatic cnt(input int n, input logic [7:0] v, input logic c,
                       output int k);
        k = 0;
        repeat (n) begin
            tick(1);
            if (txd === v && txc === c) k++;
        end
    endtask
    task automatic wait_st(input logic [1:0] s, output int k);
        k = 0;
        while (st === s && k < 2000) begin
            tick(1);
            k++;
        end
    endtask
    task automatic summarize();
        $display("Counts: %0d compared, %0d failed", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs();
        rdc(ALIGN_CTRL_ADDR, 8'h00);
        rdc(SYNC_FMT_ADDR, 8'h00);
        wr(7'h05, 8'hFF);
        rdc(7'h05, 8'h00);
        wr(ALIGN_CTRL_ADDR, 8'hFF);
        rdc(ALIGN_CTRL_ADDR, 8'h97);
        wr(ALIGN_CTRL_ADDR, 8'h00);
        wr(SYNC_FMT_ADDR, 8'hFF);
        rdc(SYNC_FMT_ADDR, 8'hCF);
        $display("test regs done");
    endtask
    task automatic t_sync();
        int k;
        wr(SYNC_FMT_ADDR, 8'hC0);
        cnt(20, K28_5, 1'b1, k);
        chk(k == 20, "soft sync K28.5");
        hold = 1'b1;
        wr(SYNC_FMT_ADDR, 8'h40);
        wait_st(2'h0, k);
        chk(st !== 2'h0, "pin ignored");
        wr(SYNC_FMT_ADDR, 8'h00);
        tick(10);
        chk(st === 2'h0, "pin followed");
        $display("test sync done");
    endtask
    task automatic t_ila();
        logic [7:0] c1[4] = '{8'h00, 8'h80, 8'h80, 8'h01};
        logic [4:0] fp[4] = '{5'h02, 5'h02, 5'h00, 5'h02};
        int         ex[4] = '{40, 24, 8, 0};
        int         k;
        for (int i = 0; i < 4; i++) begin
            hold = 1'b1;
            fpm = fp[i];
            wr(ALIGN_CTRL_ADDR, c1[i]);
            hold = 1'b0;
            wait_st(2'h0, k);
            if (ex[i] > 0) begin
                tick(1);
                chk(txd === K28_0 && txc === 1'b1, "first octet");
                k = 1;
            end else begin
                k = 0;
            end
            while (st === 2'h1 && k < 2000) begin
                tick(1);
                k++;
            end
            chk(k == ex[i] && st === 2'h2, "alignment length");
        end
        $display("test alignment done");
    endtask
    task automatic t_data(input logic [7:0] f, e1, e2);
        int k;
        hold = 1'b1;
        wr(SYNC_FMT_ADDR, f);
        k = 0;
        sv = 1'b1;
        smp = 14'h2A5B;
        while (sr === 1'b1 && k < 20) begin
            tick(1);
            k++;
        end
        sv = 1'b0;
        chk(k == 8, "fifo fill");
        hold = 1'b0;
        k = 0;
        while (!(txd === 8'hA9 && txc === 1'b0) && k < 2000) begin
            tick(1);
            k++;
        end
        tick(1);
        chk(txd === e1 && txc === 1'b0, "second octet");
        tick(1);
        chk(txd === e2 && txc === 1'b0, "third octet");
        tick(100);
        chk(sr === 1'b1, "fifo drained");
        $display("test data done");
    endtask
    task automatic t_mark();
        logic [7:0] c1[7] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h05, 8'h07,
                              8'h05};
        logic [7:0] fm[7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h00, 8'h00,
                              8'h00};
        logic [7:0] kv[7] = '{K28_7, K28_7, K28_7, K28_7, K28_3, K28_7,
                              K28_7};
        int         ex[7] = '{40, 20, 10, 5, 8, 32, 0};
        int         k;
        for (int i = 0; i < 7; i++) begin
            wr(SYNC_FMT_ADDR, fm[i]);
            wr(ALIGN_CTRL_ADDR, c1[i]);
            tick(40);
            cnt(80, kv[i], 1'b1, k);
            chk(k == ex[i], "marker count");
        end
        $display("test markers done");
    endtask
    task automatic t_pat();
        int k;
        wr(SYNC_FMT_ADDR, 8'h00);
        wr(ALIGN_CTRL_ADDR, 8'h11);
        cnt(40, 8'h00, 1'b0, k);
        chk(k < 40, "pattern active");
        wr(ALIGN_CTRL_ADDR, 8'h01);
        cnt(40, 8'h00, 1'b0, k);
        chk(k == 40, "pattern off");
        $display("test pattern done");
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            $display("CHECK FAILED at %0t: timeout", $time);
            summarize();
        end
    end

    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        sen_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        hold = 1'b0;
        fpm = 5'h00;
        sv = 1'b0;
        smp = 14'h0000;
        tick(3);
        chk(txd === K28_5 && txc === 1'b1 && st === 2'h0 && sr === 1'b1,
            "reset outputs");
        tick(3);
        rst_n = 1'b1;
        tick(3);
        t_regs();
        t_sync();
        t_ila();
        t_data(8'h00, 8'h6C, 8'hA9);
        t_data(8'h0C, 8'h6A, 8'h96);
        t_mark();
        t_pat();
        summarize();
    end
endmodule // tb_top
